// *** fdr_pkg.sv ***
// Constants, register map and state types for the fan drive ramp controller.
package fdr_pkg;

	// Time base: a tenth of a second and the slow 1.6 s step unit.
	localparam int unsigned CLK_HZ       = 40_000_000;
	localparam int unsigned TENTH_MS     = 100;
	localparam int unsigned TENTH_CYCLES = CLK_HZ / 1000 * TENTH_MS;
	localparam int unsigned SLOW_MS      = 1600;
	localparam logic [4:0]  SLOW_TENTHS  = 5'(SLOW_MS / TENTH_MS);

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_SYS_STOPV = 6'h08;
	localparam logic [5:0] IDX_CPU_STOPV = 6'h09;
	localparam logic [5:0] IDX_SYS_KICK  = 6'h0a;
	localparam logic [5:0] IDX_CPU_KICK  = 6'h0b;
	localparam logic [5:0] IDX_SYS_STOPT = 6'h0c;
	localparam logic [5:0] IDX_CPU_STOPT = 6'h0d;
	localparam logic [5:0] IDX_STEP_DN   = 6'h0e;
	localparam logic [5:0] IDX_STEP_UP   = 6'h0f;
	localparam logic [5:0] IDX_CFG       = 6'h12;
	localparam logic [5:0] IDX_CTRL      = 6'h20;
	localparam logic [5:0] IDX_SYS_TGT   = 6'h21;
	localparam logic [5:0] IDX_CPU_TGT   = 6'h22;
	localparam logic [5:0] IDX_SYS_LVL   = 6'h24;
	localparam logic [5:0] IDX_CPU_LVL   = 6'h25;
	localparam logic [5:0] IDX_STATE     = 6'h26;

	// Field positions.
	localparam int unsigned CFG_SYS_HOLD = 5;
	localparam int unsigned CFG_CPU_HOLD = 4;
	localparam logic [7:0]  CFG_MASK     = 8'h30;
	localparam int unsigned CTRL_SYS_RUN = 0;
	localparam int unsigned CTRL_CPU_RUN = 1;
	localparam int unsigned CTRL_AUTO    = 2;
	localparam int unsigned CTRL_SYS_COLD = 3;
	localparam int unsigned CTRL_CPU_COLD = 4;
	localparam logic [7:0]  CTRL_MASK    = 8'h1f;

	// Reset values.
	localparam logic [7:0] RST_STOPV   = 8'h01;
	localparam logic [7:0] RST_KICK    = 8'h01;
	localparam logic [7:0] RST_STOPT   = 8'h3c;
	localparam logic [7:0] RST_STEP    = 8'h0a;
	localparam logic [7:0] RST_CFG     = 8'h00;
	localparam logic [7:0] RST_CTRL    = 8'h00;
	localparam logic [7:0] RST_TGT     = 8'h00;

	typedef enum logic [3:0] {
		fdr_off  = 4'h1,
		fdr_kick = 4'h2,
		fdr_on   = 4'h4,
		fdr_stop = 4'h8
	} fdr_state_t;

	// Per-fan ramp state.
	typedef struct packed {
		fdr_state_t  state;
		logic [7:0]  level;
		logic [7:0]  lim;
		logic [7:0]  span;
		logic [7:0]  rem;
		logic [15:0] acc;
		logic [7:0]  icnt;
		logic        run;
	} fdr_chan_t;

	// Top-level state: bus, registers and time base.
	typedef struct packed {
		logic        wreq;
		logic [7:0]  rdata;
		logic [7:0]  sys_stopv;
		logic [7:0]  cpu_stopv;
		logic [7:0]  sys_kick;
		logic [7:0]  cpu_kick;
		logic [7:0]  sys_stopt;
		logic [7:0]  cpu_stopt;
		logic [7:0]  step_dn;
		logic [7:0]  step_up;
		logic [7:0]  cfg;
		logic [7:0]  ctrl;
		logic [7:0]  sys_tgt;
		logic [7:0]  cpu_tgt;
		logic [21:0] div;
		logic [4:0]  slow;
		logic        tick_tenth;
		logic        tick_slow;
	} fdr_top_t;

endpackage

// *** fdr_channel.sv ***
// Ramp engine for one fan drive output.
`timescale 1ns/1ps
module fdr_channel
	import fdr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       tick_tenth,
	input  wire logic       tick_slow,
	input  wire logic       auto_mode,
	input  wire logic       run,
	input  wire logic       cold,
	input  wire logic       min_hold,
	input  wire logic [7:0] kick,
	input  wire logic [7:0] stop_val,
	input  wire logic [7:0] stop_time,
	input  wire logic [7:0] step_up,
	input  wire logic [7:0] step_down,
	input  wire logic [7:0] target,
	output logic      [7:0] level,
	output fdr_state_t      state
);

	fdr_chan_t s;
	fdr_chan_t n;
	logic [7:0] aim;
	logic [7:0] ivl;
	logic       dec;
	logic       add;

	// Next-state logic; the stop decay spreads lim steps over span tenths
	// with an accumulator so no divider is needed.
	always_comb begin
		n = s;
		n.run = run;
		aim = cold ? (min_hold ? stop_val : 8'h00) : target;
		ivl = (aim > s.level) ? step_up : step_down;
		dec = (s.acc >= {8'h00, s.span}) && (s.level != 8'h00);
		add = tick_tenth && (s.rem != 8'h00);
		case (s.state)
			fdr_off: begin
				if (run && !s.run) begin
					n.state = fdr_kick;
					n.level = 8'h00;
					n.lim   = kick;
				end
			end
			fdr_kick: begin
				if (s.level >= s.lim) begin
					n.state = fdr_on;
					n.icnt  = 8'h00;
				end else if (tick_tenth) begin
					n.level = s.level + 8'h01;
				end
			end
			fdr_on: begin
				if (auto_mode && tick_slow) begin
					if ({1'b0, s.icnt} + 9'h001 >= {1'b0, ivl}) begin
						n.icnt = 8'h00;
						if (aim > s.level) begin
							n.level = s.level + 8'h01;
						end else if (aim < s.level) begin
							n.level = s.level - 8'h01;
						end
					end else begin
						n.icnt = s.icnt + 8'h01;
					end
				end
			end
			fdr_stop: begin
				if (run && !s.run) begin
					n.state = fdr_kick;
					n.level = 8'h00;
					n.lim   = kick;
				end else if (s.rem == 8'h00 && !dec) begin
					n.state = fdr_off;
					n.level = 8'h00;
					n.acc   = 16'h0000;
				end else begin
					n.acc = s.acc + (add ? {8'h00, s.lim} : 16'h0000)
						- (dec ? {8'h00, s.span} : 16'h0000);
					n.rem   = add ? s.rem - 8'h01 : s.rem;
					n.level = dec ? s.level - 8'h01 : s.level;
				end
			end
			default: n.state = fdr_off;
		endcase
		// Dropping run in a driven state always starts the decay.
		if (!run && (s.state == fdr_kick || s.state == fdr_on)) begin
			n.state = fdr_stop;
			n.level = stop_val;
			n.lim   = stop_val;
			n.span  = stop_time;
			n.rem   = stop_time;
			n.acc   = 16'h0000;
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s       <= '0;
			s.state <= fdr_off;
		end else begin
			s <= n;
		end
	end

	assign level = s.level;
	assign state = s.state;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_kick_step: assert property (s.state == fdr_kick && run && s.level < s.lim && tick_tenth
		|=> s.level == $past(s.level) + 8'h01)
		else $error("kick ramp did not step up by one");
	a_stop_load: assert property (s.state == fdr_on && !run
		|=> s.state == fdr_stop && s.level == $past(stop_val) && s.rem == $past(stop_time))
		else $error("stop decay did not start at stop value");
	a_stop_finish: assert property (s.state == fdr_stop && !run && s.rem == 8'h00
		&& s.acc < {8'h00, s.span} |=> s.state == fdr_off && s.level == 8'h00)
		else $error("stop decay did not end at zero");
	a_stop_monotone: assert property (s.state == fdr_stop && !run && s.level <= s.lim
		|=> s.level <= $past(s.level) && $past(s.level) - s.level <= 8'h01)
		else $error("stop decay moved by more than one step");
	a_auto_down: assert property (s.state == fdr_on && run && auto_mode && tick_slow
		&& aim < s.level && s.icnt + 8'h01 >= ivl |=> s.level == $past(s.level) - 8'h01)
		else $error("automatic step down missed");
	a_auto_up: assert property (s.state == fdr_on && run && auto_mode && tick_slow
		&& aim > s.level && s.icnt + 8'h01 < ivl |=> s.level == $past(s.level))
		else $error("automatic step up came before its interval");
	a_cold_hold: assert property (s.state == fdr_on && run && auto_mode && cold && min_hold
		&& s.level == stop_val && $stable(stop_val) |=> s.level == $past(stop_val))
		else $error("cold fan left its stop value");

endmodule

// *** fdr_top.sv ***
// Register file, time base and two ramp engines for the fan drive controller.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module fdr_top
	import fdr_pkg::*;
#(
	parameter int unsigned TENTH_COUNT = TENTH_CYCLES
)
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic      [7:0]  system_fan_drive,
	output logic      [7:0]  processor_fan_drive
);

	fdr_top_t   s;
	fdr_top_t   n;
	logic [5:0] idx;
	logic [7:0] wbyte;
	logic [7:0] sys_level;
	logic [7:0] cpu_level;
	fdr_state_t sys_state;
	fdr_state_t cpu_state;

	assign idx   = address[7:2];
	assign wbyte = writedata[7:0];

	// Time base, bus handshake and register writes in one next-state block.
	always_comb begin
		n = s;
		n.tick_tenth = 1'b0;
		n.tick_slow  = 1'b0;
		// A 0.1 s tick, and a 1.6 s tick every sixteenth of those.
		if (s.div == 22'(TENTH_COUNT - 1)) begin
			n.div        = 22'h000000;
			n.tick_tenth = 1'b1;
			if (s.slow == SLOW_TENTHS - 5'h01) begin
				n.slow      = 5'h00;
				n.tick_slow = 1'b1;
			end else begin
				n.slow = s.slow + 5'h01;
			end
		end else begin
			n.div = s.div + 22'h000001;
		end
		// Waitrequest drops for one cycle, one cycle after the request.
		// The extra cycle lets the read mux settle into a flop, so readdata
		// comes straight from a register at the cost of one wait state.
		if (!s.wreq) begin
			n.wreq = 1'b1;
		end else if (read || write) begin
			n.wreq  = 1'b0;
			n.rdata = 8'h00;
			if (idx == IDX_SYS_STOPV) begin
				n.rdata = s.sys_stopv;
			end else if (idx == IDX_CPU_STOPV) begin
				n.rdata = s.cpu_stopv;
			end else if (idx == IDX_SYS_KICK) begin
				n.rdata = s.sys_kick;
			end else if (idx == IDX_CPU_KICK) begin
				n.rdata = s.cpu_kick;
			end else if (idx == IDX_SYS_STOPT) begin
				n.rdata = s.sys_stopt;
			end else if (idx == IDX_CPU_STOPT) begin
				n.rdata = s.cpu_stopt;
			end else if (idx == IDX_STEP_DN) begin
				n.rdata = s.step_dn;
			end else if (idx == IDX_STEP_UP) begin
				n.rdata = s.step_up;
			end else if (idx == IDX_CFG) begin
				n.rdata = s.cfg;
			end else if (idx == IDX_CTRL) begin
				n.rdata = s.ctrl;
			end else if (idx == IDX_SYS_TGT) begin
				n.rdata = s.sys_tgt;
			end else if (idx == IDX_CPU_TGT) begin
				n.rdata = s.cpu_tgt;
			end else if (idx == IDX_SYS_LVL) begin
				n.rdata = sys_level;
			end else if (idx == IDX_CPU_LVL) begin
				n.rdata = cpu_level;
			end else if (idx == IDX_STATE) begin
				n.rdata = {cpu_state, sys_state};
			end
		end
		// A write lands at the edge where the master sees waitrequest low.
		if (!s.wreq && write && byteenable[0]) begin
			if (idx == IDX_SYS_STOPV) begin
				n.sys_stopv = wbyte;
			end else if (idx == IDX_CPU_STOPV) begin
				n.cpu_stopv = wbyte;
			end else if (idx == IDX_SYS_KICK) begin
				n.sys_kick = wbyte;
			end else if (idx == IDX_CPU_KICK) begin
				n.cpu_kick = wbyte;
			end else if (idx == IDX_SYS_STOPT) begin
				n.sys_stopt = wbyte;
			end else if (idx == IDX_CPU_STOPT) begin
				n.cpu_stopt = wbyte;
			end else if (idx == IDX_STEP_DN) begin
				n.step_dn = wbyte;
			end else if (idx == IDX_STEP_UP) begin
				n.step_up = wbyte;
			end else if (idx == IDX_CFG) begin
				n.cfg = wbyte & CFG_MASK;
			end else if (idx == IDX_CTRL) begin
				n.ctrl = wbyte & CTRL_MASK;
			end else if (idx == IDX_SYS_TGT) begin
				n.sys_tgt = wbyte;
			end else if (idx == IDX_CPU_TGT) begin
				n.cpu_tgt = wbyte;
			end
		end
	end

	// State register with documented reset values.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s           <= '0;
			s.wreq      <= 1'b1;
			s.sys_stopv <= RST_STOPV;
			s.cpu_stopv <= RST_STOPV;
			s.sys_kick  <= RST_KICK;
			s.cpu_kick  <= RST_KICK;
			s.sys_stopt <= RST_STOPT;
			s.cpu_stopt <= RST_STOPT;
			s.step_dn   <= RST_STEP;
			s.step_up   <= RST_STEP;
			s.cfg       <= RST_CFG;
			s.ctrl      <= RST_CTRL;
			s.sys_tgt   <= RST_TGT;
			s.cpu_tgt   <= RST_TGT;
		end else begin
			s <= n;
		end
	end

	assign readdata    = {24'h000000, s.rdata};
	assign waitrequest = s.wreq;

	// System fan engine.
	fdr_channel u_sys (
		.clk        (clk),
		.rst_b      (rst_b),
		.tick_tenth (s.tick_tenth),
		.tick_slow  (s.tick_slow),
		.auto_mode  (s.ctrl[CTRL_AUTO]),
		.run        (s.ctrl[CTRL_SYS_RUN]),
		.cold       (s.ctrl[CTRL_SYS_COLD]),
		.min_hold   (s.cfg[CFG_SYS_HOLD]),
		.kick       (s.sys_kick),
		.stop_val   (s.sys_stopv),
		.stop_time  (s.sys_stopt),
		.step_up    (s.step_up),
		.step_down  (s.step_dn),
		.target     (s.sys_tgt),
		.level      (sys_level),
		.state      (sys_state)
	);

	// Processor fan engine; same ramp, its own kick and stop settings.
	fdr_channel u_cpu (
		.clk        (clk),
		.rst_b      (rst_b),
		.tick_tenth (s.tick_tenth),
		.tick_slow  (s.tick_slow),
		.auto_mode  (s.ctrl[CTRL_AUTO]),
		.run        (s.ctrl[CTRL_CPU_RUN]),
		.cold       (s.ctrl[CTRL_CPU_COLD]),
		.min_hold   (s.cfg[CFG_CPU_HOLD]),
		.kick       (s.cpu_kick),
		.stop_val   (s.cpu_stopv),
		.stop_time  (s.cpu_stopt),
		.step_up    (s.step_up),
		.step_down  (s.step_dn),
		.target     (s.cpu_tgt),
		.level      (cpu_level),
		.state      (cpu_state)
	);

	assign system_fan_drive    = sys_level;
	assign processor_fan_drive = cpu_level;

	sequence s_cpu_go;
		cpu_state == fdr_off && !$past(s.ctrl[CTRL_CPU_RUN]) && s.ctrl[CTRL_CPU_RUN];
	endsequence

	sequence s_cpu_kicked;
		cpu_state == fdr_kick && cpu_level == 8'h00;
	endsequence

	a_cpu_start: assert property (@(posedge clk) disable iff (!rst_b)
		s_cpu_go |=> s_cpu_kicked)
		else $error("processor fan did not start its kick ramp from zero");
	a_cpu_stop_load: assert property (@(posedge clk) disable iff (!rst_b)
		cpu_state == fdr_on && !s.ctrl[CTRL_CPU_RUN]
		|=> cpu_state == fdr_stop && cpu_level == $past(s.cpu_stopv))
		else $error("processor fan decay did not start at stop value");
	a_stop_defaults: assert property (@(posedge clk)
		rst_b && !$past(rst_b) |-> s.sys_stopt == RST_STOPT && s.cpu_stopt == RST_STOPT)
		else $error("stop duration registers lost their reset value");

endmodule

// *** fdr_fan_model.sv ***
// Behavioural model of one analogue fan drive stage and its motor.
`timescale 1ns/1ps
module fdr_fan_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] drive,
	output logic            spinning,
	output logic      [7:0] peak
);
	// Highest drive since the fan last came to rest, so any ramp overshoot stays visible.
	always_ff @(posedge clk) begin
		if (!rst_b || drive == 8'h00) begin
			peak <= 8'h00;
		end else if (drive > peak) begin
			peak <= drive;
		end
	end
	// A real motor needs more than a trickle to turn; this model is generous on purpose.
	assign spinning = (drive != 8'h00);
endmodule

// *** tb_top.sv ***
// Self-checking bench for the fan drive ramp controller.
`timescale 1ns/1ps
module tb_top;
	import fdr_pkg::*;
	localparam int T = 8;
	localparam int SLOW = 16 * T;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [7:0]  address = 8'h00;
	logic [31:0] writedata = 32'h0;
	logic [3:0]  byteenable = 4'hf;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [7:0]  system_fan_drive, processor_fan_drive, sys_peak, cpu_peak;
	logic [31:0] rnd = 32'hda01fc39;
	int          errors = 0;
	int          comparisons = 0;
	logic [5:0]  ridx [10] = '{6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h12, 6'h20, 6'h10,
		6'h26};
	logic [7:0]  rval [10] = '{8'h01, 8'h01, 8'h3c, 8'h3c, 8'h0a, 8'h0a, 8'h00, 8'h00, 8'h00,
		8'h11};

	// A 25 ns period gives the 40 MHz system clock.
	always #12.5 clk = ~clk;

	fdr_top #(.TENTH_COUNT(T)) fdr_top_i (.clk(clk), .rst_b(rst_b), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .system_fan_drive(system_fan_drive),
		.processor_fan_drive(processor_fan_drive));
	fdr_fan_model fdr_fan_model_sys_i (.clk(clk), .rst_b(rst_b), .drive(system_fan_drive),
		.spinning(), .peak(sys_peak));
	fdr_fan_model fdr_fan_model_cpu_i (.clk(clk), .rst_b(rst_b), .drive(processor_fan_drive),
		.spinning(), .peak(cpu_peak));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] drv(input logic f);
		return f ? processor_fan_drive : system_fan_drive;
	endfunction

	// Single exit point: counts, verdict, end of run.
	task automatic wrap_up();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			errors++;
		end
	endtask

	task automatic rng(input string what, input int n, input int lo, input int hi);
		comparisons++;
		if (n < lo || n > hi) begin
			$display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, n);
			errors++;
		end
	endtask

	// One Avalon access; the request stands until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
		input logic [3:0] be, output logic [7:0] rd);
		int n;
		@(posedge clk);
		address <= {idx, 2'b00};
		writedata <= {rnd[31:8], wd};
		byteenable <= be;
		write <= wr;
		read <= !wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 50) begin
			$display("unexpected waitrequest expected 0 seen %b", waitrequest);
			errors++;
			wrap_up();
		end
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] v);
		logic [7:0] d;
		bus(1'b1, idx, v, 4'hf, d);
	endtask

	task automatic rdc(input string what, input logic [5:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		bus(1'b0, idx, 8'h00, 4'hf, d);
		chk(what, exp, d);
	endtask

	// Waits for a drive level and reports the cycles it took; the bound guards a hang.
	task automatic wait_lvl(input logic f, input logic [7:0] v, input int lim, output int n);
		n = 0;
		while (drv(f) !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			$display("unexpected drive level expected %h seen %h", v, drv(f));
			errors++;
			wrap_up();
		end
	endtask

	// Main sequence: registers first, then hold-mode ramps, then automatic stepping.
	initial begin
		logic [7:0] k, v, s, d;
		logic       f;
		int         n;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			rdc("reset value", ridx[i], rval[i]);
		end
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			wr(6'h0a + 6'(i), rnd[7:0]);
			rdc("rw register", 6'h0a + 6'(i), rnd[7:0]);
		end
		wr(6'h0a, 8'h07);
		bus(1'b1, 6'h0a, 8'h55, 4'h0, d);
		rdc("masked write", 6'h0a, 8'h07);
		wr(6'h12, 8'hff);
		rdc("config", 6'h12, 8'h30);
		wr(6'h24, 8'hff);
		rdc("level status", 6'h24, 8'h00);
		// Kick and stop ramps for each fan, with random levels and durations.
		for (int i = 0; i < 2; i++) begin
			f = i[0];
			rnd = lfsr(rnd);
			k = 8'h03 + {5'h0, rnd[2:0]};
			v = 8'h02 + {6'h0, rnd[9:8]};
			s = 8'h02 + {5'h0, rnd[6:4]};
			wr(6'h0a + 6'(i), k);
			wr(6'h08 + 6'(i), v);
			wr(6'h0c + 6'(i), s);
			wr(6'h20, 8'h01 << i);
			wait_lvl(f, k, int'(k) * T + 20, n);
			rng("kick time", n, (int'(k) - 1) * T, int'(k) * T + 4);
			repeat (3 * T) @(posedge clk);
			chk("kick peak", k, f ? cpu_peak : sys_peak);
			chk("held level", k, drv(f));
			wr(6'h20, 8'h00);
			wait_lvl(f, v, 5, n);
			wait_lvl(f, 8'h00, int'(s) * T + 20, n);
			rng("stop time", n, (int'(s) - 1) * T, int'(s) * T + 6);
		end
		// Automatic mode: climb two steps, fall to the hold floor, then to zero.
		// Step up and step down differ so that each direction is seen to use its own interval.
		wr(6'h0f, 8'h02);
		wr(6'h0e, 8'h01);
		wr(6'h0a, 8'h03);
		wr(6'h21, 8'h05);
		wr(6'h08, 8'h02);
		wr(6'h12, 8'h20);
		wr(6'h20, 8'h05);
		wait_lvl(1'b0, 8'h03, 6 * T, n);
		wait_lvl(1'b0, 8'h05, 5 * SLOW, n);
		rng("step up time", n, 3 * SLOW - 2, 4 * SLOW + 4);
		repeat (2 * SLOW) @(posedge clk);
		chk("auto target", 8'h05, sys_peak);
		wr(6'h20, 8'h0d);
		wait_lvl(1'b0, 8'h02, 4 * SLOW, n);
		rng("step down time", n, 2 * SLOW - 2, 3 * SLOW + 4);
		repeat (2 * SLOW) @(posedge clk);
		chk("min hold", 8'h02, system_fan_drive);
		wr(6'h12, 8'h00);
		wait_lvl(1'b0, 8'h00, 3 * SLOW, n);
		rng("cold fall time", n, SLOW - 2, 2 * SLOW + 4);
		rdc("level status", 6'h24, 8'h00);
		wr(6'h20, 8'h00);
		// Processor fan cold in automatic mode: its target is ignored while the floor holds.
		wr(6'h0b, 8'h03);
		wr(6'h09, 8'h03);
		wr(6'h22, 8'h09);
		wr(6'h12, 8'h10);
		wr(6'h20, 8'h16);
		wait_lvl(1'b1, 8'h03, 6 * T, n);
		repeat (2 * SLOW) @(posedge clk);
		chk("processor min hold", 8'h03, processor_fan_drive);
		rdc("state status", 6'h26, 8'h41);
		rdc("processor level status", 6'h25, 8'h03);
		wr(6'h12, 8'h00);
		wait_lvl(1'b1, 8'h00, 4 * SLOW, n);
		rng("processor cold fall time", n, 2 * SLOW - 2, 3 * SLOW + 4);
		wr(6'h20, 8'h00);
		wrap_up();
	end
endmodule
